// >>> hdl/cmfs_defs.svh
// Purpose: Constants for the console manual-function sequencer
// Assumes: 40 MHz clk, APB register access
// Notes:   Offsets are byte addresses on a 32-bit APB
`ifndef CMFS_DEFS_SVH
`define CMFS_DEFS_SVH

// Register offsets
`define CMFS_OFF_CTRL   12'h000
`define CMFS_OFF_STATUS 12'h004
`define CMFS_OFF_ADDR   12'h008
`define CMFS_OFF_DATA   12'h00c

// Field positions and reset values
`define CMFS_CTRL_TAPE  0
`define CMFS_GRANT_RST  1'b1

// Console step timing
`define CMFS_STEP_NS    2000
`define CMFS_CLK_MHZ    40
`define CMFS_STEP_CYC   ((`CMFS_STEP_NS * `CMFS_CLK_MHZ) / 1000)

// Fixed start vectors and forced opcode bits
`define CMFS_VEC_LOW    12'h010
`define CMFS_VEC_HIGH   12'h100
`define CMFS_IR_TOP     3'h7

`endif

// >>> hdl/cmfs_pkg.sv
// Purpose: Types for the console manual-function sequencer
// Assumes: 12-bit processor words, bit 11 of a word is its MSB
// Notes:   Keys struct doubles as the one-hot function code
package cmfs_pkg;

	// Console control keys, one bit each
	typedef struct packed {
		logic init;
		logic deposit;
		logic view;
		logic dep_next;
		logic view_next;
		logic start_low;
		logic start_high;
		logic start_sw;
		logic single;
		logic resume;
	} cmfs_keys_t;

	// Data switch banks and panel levers
	typedef struct packed {
		logic [11:0] left_switch_bank;
		logic [11:0] right_switch_bank;
		logic [2:0]  ext_field_sw;
		logic        auto_sw;
		logic        mode_sw_gp;
	} cmfs_switch_t;

	// Processor flags and registers steered by the console
	typedef struct packed {
		logic        run;
		logic        cycle_done;
		logic        fetch;
		logic        defer;
		logic        exec1;
		logic        exec2;
		logic        skip;
		logic        upper;
		logic        mode_gp;
		logic        en_mem;
		logic        next_instruction_grant;
		logic        auto_lat;
		logic        dep_next_lat;
		logic        view_next_lat;
		logic        exec_one_lat;
		logic [11:0] program_counter;
		logic [11:0] memory_address_reg;
		logic [11:0] memory_buffer_reg;
		logic [11:0] instruction_reg;
		logic [11:0] second_word;
		logic [4:0]  inst_field;
		logic [4:0]  field_buffer_bits;
		logic [4:0]  data_field_bits;
		logic [5:0]  save_field_bits;
	} cmfs_cpu_t;

	// Console chain states
	typedef enum logic [2:0] {
		CH_IDLE  = 3'b001,
		CH_STEP1 = 3'b010,
		CH_STEP2 = 3'b100
	} cmfs_chain_t;

	// Processor time states of a cycle
	typedef enum logic [5:0] {
		CY_IDLE = 6'b000001,
		CY_T1   = 6'b000010,
		CY_T2   = 6'b000100,
		CY_T3   = 6'b001000,
		CY_T4   = 6'b010000,
		CY_T5   = 6'b100000
	} cmfs_cycle_t;

endpackage

// >>> hdl/cmfs_top.sv
// Purpose: Console manual-function sequencer with APB status access
// Assumes: Keys already debounced and synchronous to clk
// Notes:   Processor cycle modelled as one clk per time state
`timescale 1ns/1ps
`include "cmfs_defs.svh"
`default_nettype none

module cmfs_top
(
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               ce,
	input  wire cmfs_pkg::cmfs_keys_t   keys,
	input  wire cmfs_pkg::cmfs_switch_t sw,
	input  wire logic               power_on_clear,
	input  wire logic               mem_idle,
	input  wire logic [11:0]        mem_rd_data,
	input  wire logic               multi_cycle,
	input  wire logic [11:0]        paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	output cmfs_pkg::cmfs_cpu_t     cpu,
	output logic                    console_step_zero,
	output logic                    console_step_one,
	output logic                    console_step_two,
	output logic                    start_mem,
	output logic                    io_clear
);
	import cmfs_pkg::*;

	localparam int A_STEP = `CMFS_STEP_CYC;

	cmfs_keys_t  key_s1_q, key_s2_q, key_s3_q, func_q;
	cmfs_cpu_t   cpu_q;
	cmfs_chain_t ch_q;
	cmfs_cycle_t cy_q;
	logic        pwr_s1_q, pwr_s2_q, pwr_s3_q, pwr_q;
	logic        p0_q, p1_q, p2_q, step_zero_q;
	logic [6:0]  cnt_q;
	logic        tape_busy_q, start_mem_q, io_clear_q;
	logic [31:0] prdata_q;
	logic        pready_q, pslverr_q;
	cmfs_keys_t  key_edge;
	logic        pwr_edge, launch, held, begin_cyc, manual;

	// Lowest-numbered key wins a simultaneous press
	function automatic cmfs_keys_t pick_key(input cmfs_keys_t k);
		logic [9:0] v;
		v = k;
		return cmfs_keys_t'(v & (~v + 10'd1));
	endfunction

	////////////////////////////////////////////////////////////////////
	// Key capture

	// Two-stage sync plus delay stage for edges
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			key_s1_q <= '0;
			key_s2_q <= '0;
			key_s3_q <= '0;
			pwr_s1_q <= 1'b0;
			pwr_s2_q <= 1'b0;
			pwr_s3_q <= 1'b0;
		end
		else if (ce)
		begin
			key_s1_q <= keys;
			key_s2_q <= key_s1_q;
			key_s3_q <= key_s2_q;
			pwr_s1_q <= power_on_clear;
			pwr_s2_q <= pwr_s1_q;
			pwr_s3_q <= pwr_s2_q;
		end
	end

	// Press edges and launch gate
	assign key_edge = key_s2_q & ~key_s3_q;
	assign pwr_edge = pwr_s2_q & ~pwr_s3_q;
	assign launch   = (ch_q == CH_IDLE) && (pwr_edge ||
		((|key_edge) && !cpu_q.run && !tape_busy_q));
	assign held     = |(key_s2_q & func_q);

	////////////////////////////////////////////////////////////////////
	// Console timing chain

	// Two timed steps, a pulse at launch and one ending each
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ch_q   <= CH_IDLE;
			cnt_q  <= 7'd0;
			p0_q   <= 1'b0;
			p1_q   <= 1'b0;
			p2_q   <= 1'b0;
			func_q <= '0;
			pwr_q  <= 1'b0;
		end
		else if (ce)
		begin
			p0_q <= 1'b0;
			p1_q <= 1'b0;
			p2_q <= 1'b0;
			case (ch_q)
				CH_IDLE:
				begin
					if (launch)
					begin
						ch_q  <= CH_STEP1;
						p0_q  <= 1'b1;
						cnt_q <= 7'd0;
						pwr_q <= pwr_edge;
						func_q <= pwr_edge ? cmfs_keys_t'(10'h200) :
							pick_key(key_edge);
					end
				end
				CH_STEP1:
				begin
					if (cnt_q == 7'(A_STEP - 1))
					begin
						ch_q  <= CH_STEP2;
						p1_q  <= 1'b1;
						cnt_q <= 7'd0;
					end
					else
						cnt_q <= cnt_q + 7'd1;
				end
				CH_STEP2:
				begin
					if (cnt_q == 7'(A_STEP - 1))
					begin
						ch_q  <= CH_IDLE;
						p2_q  <= 1'b1;
						cnt_q <= 7'd0;
					end
					else
						cnt_q <= cnt_q + 7'd1;
				end
				default:
					ch_q <= CH_IDLE;
			endcase
		end
	end

	// Step zero level held while the key stays down
	always_ff @(posedge clk)
	begin
		if (reset)
			step_zero_q <= 1'b0;
		else if (ce)
		begin
			if (launch)
				step_zero_q <= 1'b1;
			else if (!held)
				step_zero_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Processor cycle timing

	assign begin_cyc = cpu_q.run && cpu_q.cycle_done && mem_idle;
	assign manual = func_q.deposit | func_q.view | cpu_q.dep_next_lat |
		cpu_q.view_next_lat | cpu_q.exec_one_lat;

	// One clk per time state
	always_ff @(posedge clk)
	begin
		if (reset)
			cy_q <= CY_IDLE;
		else if (ce)
		begin
			case (cy_q)
				CY_IDLE:
				begin
					if (begin_cyc)
						cy_q <= CY_T1;
				end
				CY_T1:   cy_q <= CY_T2;
				CY_T2:   cy_q <= CY_T3;
				CY_T3:   cy_q <= CY_T4;
				CY_T4:   cy_q <= CY_T5;
				CY_T5:   cy_q <= CY_IDLE;
				default: cy_q <= CY_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Processor flags and registers

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cpu_q <= '0;
			cpu_q.next_instruction_grant <= `CMFS_GRANT_RST;
			start_mem_q <= 1'b0;
			io_clear_q  <= 1'b0;
		end
		else if (ce)
		begin
			start_mem_q <= 1'b0;
			io_clear_q  <= 1'b0;
			// Pulse zero housekeeping
			if (p0_q && !func_q.resume)
			begin
				cpu_q.skip  <= 1'b0;
				cpu_q.upper <= 1'b0;
				cpu_q.fetch <= 1'b0;
				cpu_q.defer <= 1'b0;
				cpu_q.exec1 <= 1'b0;
				cpu_q.exec2 <= 1'b0;
			end
			// Pulse one actions
			if (p1_q)
			begin
				if (func_q.init)
				begin
					cpu_q <= '0;
					cpu_q.mode_gp <= cpu_q.mode_gp;
					cpu_q.next_instruction_grant <= `CMFS_GRANT_RST;
					cpu_q.instruction_reg <= {`CMFS_IR_TOP,
						cpu_q.instruction_reg[8:0]};
					io_clear_q <= 1'b1;
				end
				if (func_q.dep_next)
				begin
					cpu_q.dep_next_lat <= 1'b1;
					cpu_q.auto_lat <= cpu_q.auto_lat | sw.auto_sw;
				end
				if (func_q.view_next)
				begin
					cpu_q.view_next_lat <= 1'b1;
					cpu_q.auto_lat <= cpu_q.auto_lat | sw.auto_sw;
				end
				if (func_q.start_low)
					cpu_q.program_counter <= `CMFS_VEC_LOW;
				if (func_q.start_high)
					cpu_q.program_counter <= `CMFS_VEC_HIGH;
				if (func_q.start_sw)
				begin
					cpu_q.program_counter <= sw.left_switch_bank;
					cpu_q.inst_field <= cpu_q.inst_field |
						{sw.ext_field_sw, sw.left_switch_bank[11:10]};
					cpu_q.field_buffer_bits <= cpu_q.field_buffer_bits |
						{sw.ext_field_sw, sw.left_switch_bank[11:10]};
				end
				if (func_q.single)
				begin
					cpu_q.exec_one_lat <= 1'b1;
					cpu_q.auto_lat <= cpu_q.auto_lat | sw.auto_sw;
					cpu_q.en_mem <= 1'b0;
				end
			end
			// Pulse two actions
			if (p2_q)
			begin
				if (func_q.init)
				begin
					cpu_q.mode_gp <= pwr_q | sw.mode_sw_gp;
					cpu_q.inst_field[1] <= 1'b1;
					cpu_q.field_buffer_bits[1] <= 1'b1;
					cpu_q.save_field_bits[0] <= 1'b1;
					cpu_q.data_field_bits[1:0] <= 2'b11;
				end
				else
				begin
					cpu_q.run <= 1'b1;
					cpu_q.cycle_done <= 1'b1;
					cpu_q.en_mem <= !func_q.single;
					cpu_q.next_instruction_grant <= !(func_q.deposit |
						func_q.view | func_q.dep_next | func_q.view_next);
				end
				if (func_q.deposit || func_q.view)
					cpu_q.memory_address_reg <= sw.left_switch_bank;
				if (func_q.start_low || func_q.start_high || func_q.start_sw)
				begin
					cpu_q.memory_address_reg <= cpu_q.program_counter;
					cpu_q.fetch <= 1'b1;
				end
				if (func_q.single)
					cpu_q.fetch <= 1'b1;
			end
			// Cycle begins: done flag drops
			if (cy_q == CY_IDLE && begin_cyc)
				cpu_q.cycle_done <= 1'b0;
			// Time state one: carry insert or counter to address
			if (cy_q == CY_T1)
			begin
				start_mem_q <= cpu_q.en_mem;
				if (cpu_q.view_next_lat)
					cpu_q.memory_address_reg <=
						cpu_q.memory_address_reg + 12'h001;
				if (cpu_q.exec_one_lat)
					cpu_q.memory_address_reg <= cpu_q.program_counter;
			end
			// Time state two: opcode clear
			if (cy_q == CY_T2 && manual)
			begin
				if (!cpu_q.defer && !cpu_q.exec1 && !cpu_q.exec2)
					cpu_q.instruction_reg <= 12'h000;
				if (cpu_q.exec_one_lat)
					cpu_q.program_counter <= cpu_q.memory_address_reg;
			end
			// Time state three: buffer load
			if (cy_q == CY_T3)
			begin
				if ((func_q.deposit && !cpu_q.view_next_lat) ||
					cpu_q.dep_next_lat)
					cpu_q.memory_buffer_reg <= sw.right_switch_bank;
				else if (func_q.view || cpu_q.view_next_lat)
					cpu_q.memory_buffer_reg <= mem_rd_data;
				if (cpu_q.exec_one_lat)
				begin
					cpu_q.instruction_reg <= sw.left_switch_bank;
					cpu_q.memory_buffer_reg <= sw.left_switch_bank;
					if (!cpu_q.mode_gp)
						cpu_q.second_word <= sw.right_switch_bank;
				end
			end
			// Time state five: halts and latch clean-up
			if (cy_q == CY_T5)
			begin
				cpu_q.cycle_done <= 1'b1;
				if (((func_q.deposit || func_q.view) && !cpu_q.view_next_lat)
					|| cpu_q.dep_next_lat)
				begin
					cpu_q.run <= 1'b0;
					cpu_q.auto_lat <= 1'b0;
				end
				if (cpu_q.view_next_lat)
				begin
					cpu_q.run <= 1'b0;
					cpu_q.view_next_lat <= 1'b0;
					cpu_q.auto_lat <= 1'b0;
				end
				if (cpu_q.exec_one_lat && !sw.auto_sw && !multi_cycle)
				begin
					cpu_q.run <= 1'b0;
					cpu_q.auto_lat <= 1'b0;
					cpu_q.exec_one_lat <= 1'b0;
					cpu_q.en_mem <= 1'b0;
				end
			end
			// Released deposit-next rolls into view-next
			if (cpu_q.dep_next_lat && !cpu_q.run && cy_q == CY_IDLE &&
				ch_q == CH_IDLE && !key_s2_q.dep_next)
			begin
				cpu_q.dep_next_lat  <= 1'b0;
				cpu_q.view_next_lat <= 1'b1;
				cpu_q.run <= 1'b1;
				cpu_q.cycle_done <= 1'b1;
				cpu_q.en_mem <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// APB slave

	// One wait state, then a registered answer
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pready_q    <= 1'b0;
			pslverr_q   <= 1'b0;
			prdata_q    <= 32'h0000_0000;
			tape_busy_q <= 1'b0;
		end
		else if (ce)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			if (psel && penable && !pready_q)
			begin
				pready_q <= 1'b1;
				prdata_q <= 32'h0000_0000;
				case (paddr)
					`CMFS_OFF_CTRL:
					begin
						if (pwrite)
							tape_busy_q <= pwdata[`CMFS_CTRL_TAPE];
						prdata_q <= {31'h0, tape_busy_q};
					end
					`CMFS_OFF_STATUS:
						prdata_q <= {14'h0, ch_q[2], ch_q[1], step_zero_q,
							cpu_q[$bits(cmfs_cpu_t)-1 -: 15]};
					`CMFS_OFF_ADDR:
						prdata_q <= {8'h00, cpu_q.memory_address_reg,
							cpu_q.program_counter};
					`CMFS_OFF_DATA:
						prdata_q <= {8'h00, cpu_q.instruction_reg,
							cpu_q.memory_buffer_reg};
					default:
						pslverr_q <= 1'b1;
				endcase
			end
		end
	end

	// Outputs straight from flops
	assign prdata            = prdata_q;
	assign pready            = pready_q;
	assign pslverr           = pslverr_q;
	assign cpu               = cpu_q;
	assign console_step_zero = step_zero_q;
	assign console_step_one  = ch_q[1];
	assign console_step_two  = ch_q[2];
	assign start_mem         = start_mem_q;
	assign io_clear          = io_clear_q;

	////////////////////////////////////////////////////////////////////
	// Assertions

	a_launch_gate: assert property (
		@(posedge clk) disable iff (reset)
		p0_q && !pwr_q |-> $past(cpu_q.run) == 1'b0 &&
			$past(tape_busy_q) == 1'b0)
		else $error("console chain launched while busy");

	a_pulse_one_gap: assert property (
		@(posedge clk) disable iff (reset)
		p0_q |-> ##[A_STEP:A_STEP] p1_q)
		else $error("pulse one spacing wrong");

	a_pulse_two_gap: assert property (
		@(posedge clk) disable iff (reset)
		p1_q |-> ##[A_STEP:1000] p2_q)
		else $error("pulse two spacing wrong");

	a_step_zero_hold: assert property (
		@(posedge clk) disable iff (reset)
		$fell(step_zero_q) |-> $past(held) == 1'b0)
		else $error("step zero dropped with key held");

	a_final_run: assert property (
		@(posedge clk) disable iff (reset)
		p2_q && ce && !func_q.init |=> cpu_q.run && cpu_q.cycle_done)
		else $error("final pulse did not start cycle");

	a_pulse_zero_clr: assert property (
		@(posedge clk) disable iff (reset)
		p0_q && ce && !func_q.resume |=>
			!cpu_q.fetch && !cpu_q.skip && !cpu_q.upper)
		else $error("pulse zero did not clear flags");

	a_init_opcode: assert property (
		@(posedge clk) disable iff (reset)
		p1_q && ce && func_q.init |=>
			cpu_q.instruction_reg[11:9] == 3'h7 && io_clear_q)
		else $error("init did not force opcode bits");

	a_power_mode: assert property (
		@(posedge clk) disable iff (reset)
		p2_q && ce && func_q.init && pwr_q |=> cpu_q.mode_gp)
		else $error("power init missed general mode");

	a_cycle_start: assert property (
		@(posedge clk) disable iff (reset)
		cy_q == CY_T1 && $past(cy_q) == CY_IDLE |->
			$past(cpu_q.run) && $past(mem_idle))
		else $error("cycle began without run and idle");

	a_view_halt: assert property (
		@(posedge clk) disable iff (reset)
		cy_q == CY_T5 && ce && cpu_q.view_next_lat |=>
			!cpu_q.run && !cpu_q.view_next_lat)
		else $error("view-next did not halt");

endmodule

`default_nettype wire

// >>> verif/cmfs_panel.sv
// Purpose: Operator panel model driving console keys and switch banks
// Assumes: Bench sets the wanted key and switch levels
// Notes:   Levels change only right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none

module cmfs_panel
(
	input  wire logic                   clk,
	input  wire cmfs_pkg::cmfs_keys_t   press,
	input  wire cmfs_pkg::cmfs_switch_t set_sw,
	output cmfs_pkg::cmfs_keys_t        keys,
	output cmfs_pkg::cmfs_switch_t      sw
);
	import cmfs_pkg::*;

	// Keys held as levels, switches steady between edges
	always @(posedge clk)
	begin
		keys <= press;
		sw <= set_sw;
	end
endmodule

`default_nettype wire

// >>> verif/tb_console_manual_function_sequencer.sv
// Purpose: Self-checking bench for the console sequencer
// Assumes: Memory always idle, single-cycle instructions only
// Notes:   One console chain per key press, keys released between
`timescale 1ns/1ps
`default_nettype none

module tb_console_manual_function_sequencer;
	import cmfs_pkg::*;

	logic         clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic         pwr = 0, io_seen = 0, er, pready, pslverr;
	logic         st0, st1, st2, start_mem, io_clear, mem_seen = 0;
	logic [11:0]  paddr = '0, mem_rd = 12'h5a5;
	logic [31:0]  pwdata = '0, prdata, rd;
	cmfs_keys_t   press = '0, keys;
	cmfs_switch_t set_sw = '0, sw;
	cmfs_cpu_t    cpu;
	int           err_total = 0, tests_run = 0;

	// Design, panel model and clock
	cmfs_top u_cmfs_top (.clk(clk), .reset(reset), .ce(1'b1), .keys(keys),
		.sw(sw), .power_on_clear(pwr), .mem_idle(1'b1), .mem_rd_data(mem_rd),
		.multi_cycle(1'b0), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu(cpu), .console_step_zero(st0),
		.console_step_one(st1), .console_step_two(st2),
		.start_mem(start_mem), .io_clear(io_clear));
	cmfs_panel u_cmfs_panel (.clk(clk), .press(press), .set_sw(set_sw),
		.keys(keys), .sw(sw));
	initial
		forever #12.5 clk = ~clk;

	// Remember device clear and memory start pulses since reset
	always @(posedge clk)
	begin
		if (reset)
		begin
			io_seen <= 1'b0;
			mem_seen <= 1'b0;
		end
		else
		begin
			if (io_clear === 1'b1)
				io_seen <= 1'b1;
			if (start_mem === 1'b1)
				mem_seen <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task close_out;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			err_total++;
			$display("ERROR t=%0t seen %h exp %h", $time, s, e);
		end
	endtask

	task tmo(input int n);
		if (n >= 400)
		begin
			err_total++;
			close_out;
		end
	endtask

	// One APB transfer, waiting for pready under a bound
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 400);
		tmo(n);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task rst;
		@(posedge clk);
		reset <= 1;
		repeat (2) @(posedge clk);
		reset <= 0;
	endtask

	// Press and hold a key, follow the chain and the cycle after it
	task run_key(input cmfs_keys_t k, input logic p);
		int n;
		@(posedge clk);
		press <= k;
		pwr <= p;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (st1 !== 1'b1 && n < 400);
		tmo(n);
		n = 0;
		while (st2 !== 1'b1 && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		tmo(n);
		chk(n, 80);
		n = 0;
		while (st2 !== 1'b0 && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		tmo(n);
		chk(n, 80);
		repeat (12) @(posedge clk);
	endtask

	task rel;
		@(posedge clk);
		press <= '0;
		pwr <= 0;
		repeat (6) @(posedge clk);
	endtask

	// A press that must not launch the chain
	task refuse(input cmfs_keys_t k);
		int n;
		@(posedge clk);
		press <= k;
		n = 0;
		repeat (170)
		begin
			@(posedge clk);
			if (st1 === 1'b1)
				n++;
		end
		chk(n, 0);
		rel;
	endtask

	////////////////////////////////////////////////////////////////////////
	logic [9:0]  kk [3] = '{10'h010, 10'h008, 10'h004};
	logic [11:0] pcx [3] = '{12'h010, 12'h100, 12'hc05};

	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk);
		reset <= 0;
		apb(0, 12'h004, 0);
		chk(rd, 32'h10);
		apb(0, 12'h010, 0);
		chk(er, 1);
		$display("test reset done");
		set_sw.left_switch_bank <= 12'h123;
		set_sw.right_switch_bank <= 12'h456;
		run_key(10'h100, 0);
		chk(cpu.memory_address_reg, 12'h123);
		chk(cpu.memory_buffer_reg, 12'h456);
		chk(cpu.run, 0);
		chk(cpu.next_instruction_grant, 0);
		chk(mem_seen, 1);
		chk(st0, 1);
		rel;
		chk(st0, 0);
		$display("test deposit done");
		set_sw.left_switch_bank <= 12'h0aa;
		run_key(10'h080, 0);
		chk(cpu.memory_address_reg, 12'h0aa);
		chk(cpu.memory_buffer_reg, mem_rd);
		chk(cpu.run, 0);
		rel;
		apb(1, 12'h000, 1);
		refuse(10'h080);
		apb(1, 12'h000, 0);
		$display("test view done");
		run_key(10'h200, 0);
		chk(cpu.instruction_reg[11:9], 3'h7);
		chk(cpu.mode_gp, 0);
		chk({cpu.inst_field[1], cpu.field_buffer_bits[1],
			cpu.data_field_bits[1:0], cpu.save_field_bits[0]}, 5'h1f);
		chk(io_seen, 1);
		chk(cpu.run, 0);
		rel;
		run_key('0, 1);
		chk(cpu.mode_gp, 1);
		rel;
		$display("test init done");
		run_key(10'h040, 0);
		chk(cpu.memory_buffer_reg, 12'h456);
		chk({cpu.run, cpu.dep_next_lat}, 2'b01);
		chk(cpu.memory_address_reg, 12'h000);
		chk(cpu.instruction_reg, 12'h000);
		rel;
		repeat (6) @(posedge clk);
		chk(cpu.memory_address_reg, 12'h001);
		chk(cpu.memory_buffer_reg, mem_rd);
		chk({cpu.run, cpu.view_next_lat, cpu.dep_next_lat}, 0);
		$display("test dep_next done");
		rst;
		run_key(10'h020, 0);
		chk(cpu.memory_address_reg, 12'h001);
		chk(cpu.memory_buffer_reg, mem_rd);
		chk({cpu.run, cpu.view_next_lat, cpu.auto_lat}, 0);
		rel;
		$display("test view_next done");
		rst;
		set_sw.left_switch_bank <= 12'h7a0;
		set_sw.right_switch_bank <= 12'h3c3;
		run_key(10'h002, 0);
		chk(cpu.instruction_reg, 12'h7a0);
		chk(cpu.memory_buffer_reg, 12'h7a0);
		chk(cpu.second_word, 12'h3c3);
		chk(cpu.en_mem, 0);
		chk(mem_seen, 0);
		chk(cpu.run, 0);
		rel;
		$display("test single done");
		set_sw.left_switch_bank <= 12'hc05;
		set_sw.ext_field_sw <= 3'b101;
		for (int i = 0; i < 3; i++)
		begin
			rst;
			run_key(kk[i], 0);
			chk(cpu.program_counter, pcx[i]);
			chk({cpu.run, cpu.fetch}, 2'b11);
			if (i == 2)
				chk(cpu.inst_field, 5'h17);
			rel;
			if (i == 0)
				refuse(10'h080);
		end
		$display("test starts done");
		close_out;
	end
endmodule

`default_nettype wire
